//--- rtl/ahmc_amp.sv
// Purpose: amplifier end, pin-configured mode, I2S receive and clock check
// Assumes: link side clocked by the bit clock, control side by mclk
// Notes: no control port; software mode is flagged and holds the amplifier in shutdown
// Summary of operation
// RULE1: hardware mode behaviour set only by pins
// RULE2: board keeps static pins fixed in operation
// RULE3: all pins low: bridge load, 16x switching
// RULE4: shutdown input low enters shutdown, high leaves
// RULE5: processor raises sleep before dropping shutdown
// RULE6: only standard I2S frames accepted and sent
// RULE7: single rate mode, 12 to 48 kHz only
// RULE8: master ratio limits per sample rate band
// RULE9: bit clock must be 32, 48, 64 fs
// RULE10: rate pin low 16 fs, high 8 fs
// RULE11: soft clipper caps peak at four times level
// RULE12: bad clocks pull fault low, auto recover
// RULE13: both gain pins high selects software mode
// RULE14: sleep stops switching, keeps signal path alive
// RULE15: rate pin captured on leaving shutdown
`timescale 1ns/1ns
module ahmc_amp
    import ahmc_pkg::*;
(
    // clocks and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link
    ahmc_link_if.dev lnk,
    // decoded samples
    output logic [SAMP_W-1:0] samp_left,
    output logic [SAMP_W-1:0] samp_right,
    output logic samp_valid,
    // amplifier status
    output logic switching,
    output logic out_hiz,
    output logic [4:0] switch_mult,
    output logic bridge_load_mode,
    output logic sw_mode,
    output logic clock_error
);
    // ==================================================================
    // helpers
    function automatic logic near(input logic [CNT_W-1:0] n, input logic [CNT_W-1:0] r);
        near = (n + RATIO_TOL >= r) && (n <= r + RATIO_TOL);
    endfunction : near

    function automatic logic clocks_ok(input logic [CNT_W-1:0] n,
                                       input logic [BITS_W-1:0] bits);
        logic bits_ok;
        logic rate_ok;
        logic ratio_ok;
        bits_ok = (bits == FRAME_BITS_32) || (bits == FRAME_BITS_48)
            || (bits == FRAME_BITS_64); // RULE9
        rate_ok = (n >= CNT_RATE_MAX) && (n <= CNT_RATE_MIN); // RULE7
        if (n > CNT_BAND16)
            ratio_ok = near(n, RATIO_512); // RULE8
        else if (n > CNT_BAND24)
            ratio_ok = near(n, RATIO_256) || near(n, RATIO_384) || near(n, RATIO_512);
        else if (n > CNT_BAND32)
            ratio_ok = near(n, RATIO_192) || near(n, RATIO_256) || near(n, RATIO_384)
                || near(n, RATIO_512);
        else
            ratio_ok = near(n, RATIO_128) || near(n, RATIO_192) || near(n, RATIO_256)
                || near(n, RATIO_384) || near(n, RATIO_512);
        clocks_ok = bits_ok && rate_ok && ratio_ok;
    endfunction : clocks_ok

    function automatic logic [SAMP_W-1:0] clip(input logic [SAMP_W-1:0] s,
                                               input logic [CLIP_W-1:0] lvl);
        logic signed [SAMP_W:0] lim;
        logic signed [SAMP_W:0] v;
        lim = $signed({1'b0, lvl, {CLIP_SHIFT{1'b0}}});
        v = $signed({s[SAMP_W-1], s});
        clip = s;
        if (lvl != '0)
        begin
            if (v > lim)
                clip = lim[SAMP_W-1:0]; // RULE11
            else if (v < -lim)
                clip = SAMP_W'(-lim); // RULE11
        end
    endfunction : clip

    // ==================================================================
    // bit clock domain: reset release and I2S receive
    logic brst_s1_ff;
    logic brst_n_ff;
    logic lr_prev_ff;
    logic [BITS_W-1:0] pos_ff;
    logic [BITS_W-1:0] flen_ff;
    logic [SAMP_W-1:0] shift_ff;
    logic [SAMP_W-1:0] left_ff;
    logic [SAMP_W-1:0] hold_left_ff;
    logic [SAMP_W-1:0] hold_right_ff;
    logic [BITS_W-1:0] hold_bits_ff;
    logic frame_tgl_ff;
    logic lr_edge;
    logic [BITS_W-1:0] nxt_pos;

    always_ff @(posedge lnk.bclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            brst_s1_ff <= 1'b0;
            brst_n_ff <= 1'b0;
        end
        else
        begin
            brst_s1_ff <= 1'b1;
            brst_n_ff <= brst_s1_ff;
        end
    end

    // msb follows one bit after the word clock edge
    assign lr_edge = lnk.lrck != lr_prev_ff; // RULE6
    assign nxt_pos = lr_edge ? '0 : ((&pos_ff) ? pos_ff : pos_ff + 1'b1);

    always_ff @(posedge lnk.bclk or negedge brst_n_ff)
    begin
        if (!brst_n_ff)
        begin
            lr_prev_ff <= 1'b0;
            pos_ff <= '0;
            shift_ff <= '0;
        end
        else
        begin
            lr_prev_ff <= lnk.lrck;
            pos_ff <= nxt_pos;
            if (nxt_pos != '0 && nxt_pos <= BITS_W'(SAMP_W))
                shift_ff <= {shift_ff[SAMP_W-2:0], lnk.sdin}; // RULE6
        end
    end

    // frame ends on the falling word clock; slot bits past the sample width are ignored
    always_ff @(posedge lnk.bclk or negedge brst_n_ff)
    begin
        if (!brst_n_ff)
        begin
            flen_ff <= '0;
            left_ff <= '0;
            hold_left_ff <= '0;
            hold_right_ff <= '0;
            hold_bits_ff <= '0;
            frame_tgl_ff <= 1'b0;
        end
        else
        begin
            if (lr_edge && lnk.lrck)
                left_ff <= shift_ff;
            if (lr_edge && !lnk.lrck)
            begin
                hold_left_ff <= left_ff;
                hold_right_ff <= shift_ff;
                hold_bits_ff <= flen_ff; // RULE9
                frame_tgl_ff <= !frame_tgl_ff;
                flen_ff <= BITS_W'(1);
            end
            else if (!(&flen_ff))
                flen_ff <= flen_ff + 1'b1;
        end
    end

    // ==================================================================
    // master clock domain: pin and frame synchronisers
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_s1_ff;
    logic [PIN_N-1:0] pin_ff;
    logic [CLIP_W-1:0] clip_s1_ff;
    logic [CLIP_W-1:0] clip_ff;
    logic [2:0] tgl_ff;
    logic frame_ev;

    assign pin_raw[PIN_SD] = lnk.amp_shutdown_n;
    assign pin_raw[PIN_SLEEP] = lnk.sleep_select_pin;
    assign pin_raw[PIN_RATE] = lnk.switch_rate_pin;
    assign pin_raw[PIN_PAR] = lnk.parallel_load_pin;
    assign pin_raw[PIN_G0] = lnk.gain_select_pins[0];
    assign pin_raw[PIN_G1] = lnk.gain_select_pins[1];

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_ff <= '0;
            pin_ff <= '0;
            clip_s1_ff <= '0;
            clip_ff <= '0;
            tgl_ff <= '0;
        end
        else
        begin
            pin_s1_ff <= pin_raw;
            pin_ff <= pin_s1_ff;
            clip_s1_ff <= lnk.soft_clip_level_pin;
            clip_ff <= clip_s1_ff;
            tgl_ff <= {tgl_ff[1:0], frame_tgl_ff};
        end
    end

    // held words are stable for a whole frame after the toggle, far longer than the sync
    assign frame_ev = tgl_ff[2] ^ tgl_ff[1];

    // ==================================================================
    // clock check: master clocks per frame, stop watchdog
    logic [CNT_W-1:0] mcnt_ff;
    logic clk_err_ff;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mcnt_ff <= '0;
            clk_err_ff <= 1'b1;
        end
        else
        begin
            if (frame_ev)
            begin
                mcnt_ff <= CNT_W'(1);
                clk_err_ff <= !clocks_ok(mcnt_ff, hold_bits_ff); // RULE12
            end
            else if (mcnt_ff == CNT_STOP)
                clk_err_ff <= 1'b1; // RULE12
            else
                mcnt_ff <= mcnt_ff + 1'b1;
        end
    end

    // ==================================================================
    // operating state
    ahmc_state_t state_ff;
    ahmc_state_t nxt_state;
    logic hw_mode;
    logic rate_cfg_ff;
    logic par_cfg_ff;

    assign hw_mode = !(pin_ff[PIN_G0] && pin_ff[PIN_G1]); // RULE13

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            AHMC_SHUTDOWN:
                if (pin_ff[PIN_SD] && hw_mode)
                    nxt_state = AHMC_SLEEP; // RULE4
            AHMC_SLEEP:
                if (!pin_ff[PIN_SLEEP] && !clk_err_ff)
                    nxt_state = AHMC_RUN; // RULE14
            AHMC_RUN:
                if (pin_ff[PIN_SLEEP] || clk_err_ff)
                    nxt_state = AHMC_SLEEP; // RULE14
            default:
                nxt_state = AHMC_SHUTDOWN;
        endcase
        if (!pin_ff[PIN_SD] || !hw_mode)
            nxt_state = AHMC_SHUTDOWN; // RULE4
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            state_ff <= AHMC_SHUTDOWN;
        else
            state_ff <= nxt_state;
    end

    // rate and parallel pins are taken once, while leaving shutdown; later changes are ignored; gain and clip pins are used live
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rate_cfg_ff <= 1'b0; // RULE3
            par_cfg_ff <= 1'b0; // RULE3
        end
        else if (state_ff == AHMC_SHUTDOWN && nxt_state == AHMC_SLEEP)
        begin
            rate_cfg_ff <= pin_ff[PIN_RATE]; // RULE15
            par_cfg_ff <= pin_ff[PIN_PAR]; // RULE1
        end
    end

    // ==================================================================
    // outputs
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            samp_left <= '0;
            samp_right <= '0;
            samp_valid <= 1'b0;
        end
        else
        begin
            samp_valid <= frame_ev && state_ff != AHMC_SHUTDOWN; // RULE14
            if (frame_ev && state_ff != AHMC_SHUTDOWN)
            begin
                samp_left <= clip(hold_left_ff, clip_ff);
                samp_right <= clip(hold_right_ff, clip_ff);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            switching <= 1'b0;
            out_hiz <= 1'b1;
            switch_mult <= SWITCH_X16;
            bridge_load_mode <= 1'b1;
            sw_mode <= 1'b0;
            clock_error <= 1'b0;
        end
        else
        begin
            switching <= nxt_state == AHMC_RUN;
            out_hiz <= nxt_state != AHMC_RUN; // RULE14
            switch_mult <= rate_cfg_ff ? SWITCH_X8 : SWITCH_X16; // RULE10
            bridge_load_mode <= !par_cfg_ff; // RULE3
            sw_mode <= !hw_mode; // RULE13
            clock_error <= clk_err_ff && state_ff != AHMC_SHUTDOWN; // RULE12
        end
    end

    // fault line only ever pulled low, released once the clocks check good
    assign lnk.fault_o = 1'b0;
    assign lnk.fault_oe = clock_error; // RULE12
endmodule : ahmc_amp

//--- rtl/ahmc_pkg.sv
// Purpose: shared constants for the pin-configured amplifier link
// Assumes: master clock of 10 MHz on both ends
// Notes: counts derived from rates in Hz or times in ns at the master clock rate
package ahmc_pkg;
    // ==================================================================
    // clocking and widths
    localparam int MCLK_HZ = 10_000_000;
    localparam int MCLK_PERIOD_NS = 100;
    localparam int SAMP_W = 16;
    localparam int CNT_W = 12;
    localparam int BITS_W = 7;
    localparam int CLIP_W = 14;
    localparam int CLIP_SHIFT = 2;
    // ==================================================================
    // frame lengths in bit clocks and master clock ratios
    localparam logic [BITS_W-1:0] FRAME_BITS_32 = 7'h20;
    localparam logic [BITS_W-1:0] FRAME_BITS_48 = 7'h30;
    localparam logic [BITS_W-1:0] FRAME_BITS_64 = 7'h40;
    localparam logic [CNT_W-1:0] RATIO_128 = 12'h080;
    localparam logic [CNT_W-1:0] RATIO_192 = 12'h0C0;
    localparam logic [CNT_W-1:0] RATIO_256 = 12'h100;
    localparam logic [CNT_W-1:0] RATIO_384 = 12'h180;
    localparam logic [CNT_W-1:0] RATIO_512 = 12'h200;
    localparam logic [CNT_W-1:0] RATIO_TOL = 12'h002;
    localparam logic [CNT_W-1:0] CNT_STOP = 12'hFFF;
    // ==================================================================
    // sample rate bands, as frame lengths in master clocks
    localparam int RATE_MAX_HZ = 48_500;
    localparam int RATE_MIN_HZ = 11_500;
    localparam int BAND16_HZ = 14_000;
    localparam int BAND24_HZ = 20_000;
    localparam int BAND32_HZ = 28_000;
    localparam logic [CNT_W-1:0] CNT_RATE_MAX = CNT_W'(MCLK_HZ / RATE_MAX_HZ);
    localparam logic [CNT_W-1:0] CNT_RATE_MIN = CNT_W'(MCLK_HZ / RATE_MIN_HZ);
    localparam logic [CNT_W-1:0] CNT_BAND16 = CNT_W'(MCLK_HZ / BAND16_HZ);
    localparam logic [CNT_W-1:0] CNT_BAND24 = CNT_W'(MCLK_HZ / BAND24_HZ);
    localparam logic [CNT_W-1:0] CNT_BAND32 = CNT_W'(MCLK_HZ / BAND32_HZ);
    // ==================================================================
    // switching rate multipliers
    localparam logic [4:0] SWITCH_X16 = 5'h10;
    localparam logic [4:0] SWITCH_X8 = 5'h08;
    // ==================================================================
    // control pin positions in the synchroniser vector
    localparam int PIN_SD = 0;
    localparam int PIN_SLEEP = 1;
    localparam int PIN_RATE = 2;
    localparam int PIN_PAR = 3;
    localparam int PIN_G0 = 4;
    localparam int PIN_G1 = 5;
    localparam int PIN_N = 6;
    // ==================================================================
    // host timing
    localparam int SLEEP_LEAD_NS = 20_000;
    localparam logic [7:0] SLEEP_LEAD_CYC =
        8'((SLEEP_LEAD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam logic [1:0] SEL_BITS_32 = 2'h0;
    localparam logic [1:0] SEL_BITS_48 = 2'h1;
    typedef enum {AHMC_SHUTDOWN, AHMC_SLEEP, AHMC_RUN} ahmc_state_t;
endpackage : ahmc_pkg

//--- rtl/ahmc_link_if.sv
// Purpose: serial audio link and control pins between processor and amplifier
// Assumes: fault line is open drain with a pull-up
// Notes: resolves the fault wire level from the enable
`timescale 1ns/1ns
interface ahmc_link_if;
    import ahmc_pkg::*;
    // ==================================================================
    // serial audio port
    logic bclk;
    logic lrck;
    logic sdin;
    // ==================================================================
    // control pins
    logic amp_shutdown_n;
    logic sleep_select_pin;
    logic switch_rate_pin;
    logic parallel_load_pin;
    logic [1:0] gain_select_pins;
    logic [CLIP_W-1:0] soft_clip_level_pin;
    // ==================================================================
    // open drain fault line
    logic fault_o;
    logic fault_oe;
    logic amp_fault_n;
    assign amp_fault_n = !(fault_oe && !fault_o);

    modport dev (
        input bclk, lrck, sdin, amp_shutdown_n, sleep_select_pin, switch_rate_pin,
        input parallel_load_pin, gain_select_pins, soft_clip_level_pin,
        output fault_o, fault_oe
    );
    modport proc (
        output bclk, lrck, sdin, amp_shutdown_n, sleep_select_pin, switch_rate_pin,
        output parallel_load_pin, gain_select_pins, soft_clip_level_pin,
        input amp_fault_n
    );
endinterface : ahmc_link_if

//--- rtl/ahmc_proc.sv
// Purpose: processor end, makes bit and word clocks and drives control pins
// Assumes: bit clock derived from mclk by a divider, so one clock domain
// Notes: static pins follow the user only while the amplifier is shut down
`timescale 1ns/1ns
module ahmc_proc
    import ahmc_pkg::*;
(
    // clocks and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link
    ahmc_link_if.proc lnk,
    // audio source
    input wire logic [SAMP_W-1:0] src_left,
    input wire logic [SAMP_W-1:0] src_right,
    output logic src_take,
    // link format
    input wire logic [3:0] bclk_half,
    input wire logic [1:0] frame_sel,
    // control requests
    input wire logic shutdown_req,
    input wire logic sleep_req,
    input wire logic rate_high,
    input wire logic parallel_sel,
    input wire logic [1:0] gain_sel,
    input wire logic [CLIP_W-1:0] clip_level,
    // status
    output logic fault_seen
);
    // ==================================================================
    // bit clock divider
    logic [3:0] div_ff;
    logic bclk_ff;
    logic fall;

    assign fall = (div_ff + 1'b1 >= bclk_half) && bclk_ff;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_ff <= '0;
            bclk_ff <= 1'b0;
        end
        else if (div_ff + 1'b1 >= bclk_half)
        begin
            div_ff <= '0;
            bclk_ff <= !bclk_ff;
        end
        else
            div_ff <= div_ff + 1'b1;
    end

    // ==================================================================
    // I2S framing, changed on the falling bit clock
    logic [BITS_W-1:0] bits;
    logic [BITS_W-1:0] cnt_ff;
    logic [BITS_W-1:0] nxt_cnt;
    logic [SAMP_W-1:0] shift_ff;
    logic [SAMP_W-1:0] right_ff;
    logic lrck_ff;

    assign bits = (frame_sel == SEL_BITS_32) ? FRAME_BITS_32 :
        (frame_sel == SEL_BITS_48) ? FRAME_BITS_48 : FRAME_BITS_64; // RULE9
    assign nxt_cnt = (cnt_ff + 1'b1 >= bits) ? '0 : cnt_ff + 1'b1;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= '0;
            lrck_ff <= 1'b0;
            shift_ff <= '0;
            right_ff <= '0;
            src_take <= 1'b0;
        end
        else
        begin
            src_take <= fall && nxt_cnt == BITS_W'(1);
            if (fall)
            begin
                cnt_ff <= nxt_cnt;
                lrck_ff <= nxt_cnt >= (bits >> 1); // RULE6
                if (nxt_cnt == BITS_W'(1))
                begin
                    shift_ff <= src_left; // RULE6
                    right_ff <= src_right;
                end
                else if (nxt_cnt == (bits >> 1) + 1'b1)
                    shift_ff <= right_ff;
                else
                    shift_ff <= {shift_ff[SAMP_W-2:0], 1'b0};
            end
        end
    end

    assign lnk.bclk = bclk_ff;
    assign lnk.lrck = lrck_ff;
    assign lnk.sdin = shift_ff[SAMP_W-1];

    // ==================================================================
    // shutdown sequencing: sleep first, then shutdown after a lead time
    logic sd_n_ff;
    logic sleep_ff;
    logic [7:0] lead_ff;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sd_n_ff <= 1'b0;
            sleep_ff <= 1'b1;
            lead_ff <= '0;
        end
        else if (shutdown_req)
        begin
            sleep_ff <= 1'b1; // RULE5
            if (lead_ff >= SLEEP_LEAD_CYC)
                sd_n_ff <= 1'b0; // RULE5
            else
                lead_ff <= lead_ff + 1'b1;
        end
        else
        begin
            sd_n_ff <= 1'b1;
            sleep_ff <= sleep_req;
            lead_ff <= sd_n_ff ? '0 : SLEEP_LEAD_CYC;
        end
    end

    // static pins may only move while the amplifier is held in shutdown
    logic rate_ff;
    logic par_ff;
    logic [1:0] gain_ff;
    logic [CLIP_W-1:0] clip_ff;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rate_ff <= 1'b0;
            par_ff <= 1'b0;
            gain_ff <= '0;
            clip_ff <= '0;
        end
        else if (!sd_n_ff && shutdown_req)
        begin
            rate_ff <= rate_high; // RULE2
            par_ff <= parallel_sel;
            gain_ff <= gain_sel;
            clip_ff <= clip_level;
        end
    end

    assign lnk.amp_shutdown_n = sd_n_ff;
    assign lnk.sleep_select_pin = sleep_ff;
    assign lnk.switch_rate_pin = rate_ff;
    assign lnk.parallel_load_pin = par_ff;
    assign lnk.gain_select_pins = gain_ff;
    assign lnk.soft_clip_level_pin = clip_ff;

    // ==================================================================
    // fault line sync
    logic flt_s1_ff;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flt_s1_ff <= 1'b0;
            fault_seen <= 1'b0;
        end
        else
        begin
            flt_s1_ff <= !lnk.amp_fault_n;
            fault_seen <= flt_s1_ff;
        end
    end
endmodule : ahmc_proc

//--- test/ahmc_chk_sva.sv
// Purpose: wire checks on the link
// Assumes: bclk made in mclk domain
// Notes: first half frame skipped
`timescale 1ns/1ns
module ahmc_chk
    import ahmc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link
    input wire logic bclk,
    input wire logic lrck,
    input wire logic sdin,
    input wire logic amp_shutdown_n,
    input wire logic sleep_select_pin,
    input wire logic switch_rate_pin,
    input wire logic parallel_load_pin,
    input wire logic [1:0] gain_select_pins,
    input wire logic [CLIP_W-1:0] soft_clip_level_pin,
    input wire logic fault_o,
    input wire logic fault_oe,
    input wire logic amp_fault_n
);
    // ==================================================================
    // bit clocks per half frame
    logic bclk_q_ff;
    logic lrck_q_ff;
    logic seen_ff;
    logic [BITS_W-1:0] nbits_ff;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {bclk_q_ff, lrck_q_ff, seen_ff} <= '0;
            nbits_ff <= '0;
        end
        else
        begin
            {bclk_q_ff, lrck_q_ff} <= {bclk, lrck};
            seen_ff <= seen_ff || (lrck != lrck_q_ff);
            if (lrck != lrck_q_ff)
                nbits_ff <= '0;
            else if (bclk && !bclk_q_ff)
                nbits_ff <= nbits_ff + 7'h01;
        end
    end
    // ==================================================================
    // assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    AST_LRCK_EDGE: assert property ($changed(lrck) |-> $fell(bclk))
        else $error("lrck off edge");
    AST_SDIN_EDGE: assert property ($changed(sdin) |-> $fell(bclk))
        else $error("sdin off edge");
    AST_HALF_BITS: assert property (seen_ff && lrck != lrck_q_ff
        |-> nbits_ff inside {7'h10, 7'h18, 7'h20}) else $error("bad half frame");
    AST_SLEEP_FIRST: assert property ($fell(amp_shutdown_n)
        |-> sleep_select_pin && $past(sleep_select_pin, 8)) else $error("no sleep lead");
    AST_SLEEP_IN_SD: assert property (!amp_shutdown_n |-> sleep_select_pin)
        else $error("no sleep");
    AST_RATE_HOLD: assert property (amp_shutdown_n && $past(amp_shutdown_n)
        |-> $stable(switch_rate_pin) && $stable(parallel_load_pin)) else $error("pin moved");
    AST_TRIM_HOLD: assert property (amp_shutdown_n && $past(amp_shutdown_n)
        |-> $stable(gain_select_pins) && $stable(soft_clip_level_pin)) else $error("moved");
    AST_FAULT_DRIVE: assert property (fault_oe |-> !fault_o && !amp_fault_n)
        else $error("fault not low");
    AST_FAULT_SD: assert property (!amp_shutdown_n [*8] |-> !fault_oe)
        else $error("fault in shutdown");
    cover property ($fell(amp_fault_n));
    cover property ($rose(amp_shutdown_n));
    cover property ($fell(amp_shutdown_n));
endmodule : ahmc_chk

//--- test/test_amp_hardware_mode_config.sv
// Purpose: drives and judges both ends
// Assumes: pins move only via the processor
// Notes: reset pulsed per clock case
`timescale 1ns/1ns
module test_amp_hardware_mode_config
    import ahmc_pkg::*;
;
    // ==================================================================
    // signals and ends
    logic mclk, rst_n, shutdown_req, sleep_req, rate_high, parallel_sel, fault_seen;
    logic samp_valid, switching, out_hiz, bridge_load_mode, sw_mode, clock_error;
    logic [SAMP_W-1:0] src_left, src_right, samp_left, samp_right;
    logic [3:0] bclk_half;
    logic [1:0] frame_sel, gain_sel;
    logic [CLIP_W-1:0] clip_level;
    logic [4:0] switch_mult;
    int mismatches, checked;
    logic [6:0] tbl [7] = '{7'h14, 7'h0D, 7'h40, 7'h22, 7'h61, 7'h7D, 7'h1C};
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    ahmc_link_if lnk();
    ahmc_proc ahmc_proc_i(.mclk, .rst_n, .lnk(lnk), .src_left, .src_right,
        .src_take(), .bclk_half, .frame_sel, .shutdown_req, .sleep_req, .rate_high,
        .parallel_sel, .gain_sel, .clip_level, .fault_seen);
    ahmc_amp ahmc_amp_i(.mclk, .rst_n, .lnk(lnk), .samp_left, .samp_right,
        .samp_valid, .switching, .out_hiz, .switch_mult, .bridge_load_mode, .sw_mode,
        .clock_error);
    ahmc_chk ahmc_chk_i(.mclk, .rst_n, .bclk(lnk.bclk), .lrck(lnk.lrck), .sdin(lnk.sdin),
        .amp_shutdown_n(lnk.amp_shutdown_n), .sleep_select_pin(lnk.sleep_select_pin),
        .switch_rate_pin(lnk.switch_rate_pin), .parallel_load_pin(lnk.parallel_load_pin),
        .gain_select_pins(lnk.gain_select_pins),
        .soft_clip_level_pin(lnk.soft_clip_level_pin), .fault_o(lnk.fault_o),
        .fault_oe(lnk.fault_oe), .amp_fault_n(lnk.amp_fault_n));
    // ==================================================================
    // helpers
    task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task sd(input logic v);
        shutdown_req <= v;
        cyc(300);
    endtask : sd
    task wsw(input logic v);
        for (int i = 0; i < 4000 && switching !== v; i++) @(posedge mclk);
        chk(switching, v, "sw");
    endtask : wsw
    task wv(input int n);
        repeat (n) do @(posedge mclk); while (samp_valid !== 1'b1);
    endtask : wv
    // ==================================================================
    // scenarios
    task t_default;
        chk(switch_mult, SWITCH_X16, "mult0");
        sd(1'b0);
        wsw(1'b1);
        chk(switch_mult, SWITCH_X16, "mult");
        chk(bridge_load_mode, 1'b1, "bridge");
        wv(3);
        chk(samp_left, 16'h1234, "left");
        chk(samp_right, 16'h0234, "right");
    endtask : t_default
    task t_pins;
        rate_high <= 1'b1;
        parallel_sel <= 1'b1;
        clip_level <= 14'h0100;
        sd(1'b1);
        chk(switching, 1'b0, "sw");
        sd(1'b0);
        rate_high <= 1'b0;
        wsw(1'b1);
        chk(switch_mult, SWITCH_X8, "mult");
        chk(bridge_load_mode, 1'b0, "bridge");
        wv(3);
        chk(samp_left, 16'h0400, "clipped");
        chk(samp_right, 16'h0234, "unclipped");
        parallel_sel <= 1'b0;
        clip_level <= '0;
        gain_sel <= 2'h3;
        sd(1'b1);
        sd(1'b0);
        chk(sw_mode, 1'b1, "sw mode");
        chk(switching, 1'b0, "sw");
        gain_sel <= 2'h0;
        sd(1'b1);
        sd(1'b0);
        wsw(1'b1);
        chk(switch_mult, SWITCH_X16, "mult");
    endtask : t_pins
    task t_sleep;
        sleep_req <= 1'b1;
        cyc(20);
        chk(switching, 1'b0, "sw");
        chk(out_hiz, 1'b1, "hiz");
        wv(2);
        chk(samp_left, 16'h1234, "left");
        sleep_req <= 1'b0;
        wsw(1'b1);
    endtask : t_sleep
    task t_rates;
        foreach (tbl[k])
        begin
            rst_n <= 1'b0;
            {bclk_half, frame_sel} <= tbl[k][6:1];
            cyc(4);
            rst_n <= 1'b1;
            cyc(4000);
            chk(clock_error, tbl[k][0], "clk err");
            chk(fault_seen, tbl[k][0], "fault");
            chk(switching, !tbl[k][0], "sw");
        end
    endtask : t_rates
    task t_off;
        int n;
        n = 0;
        sd(1'b1);
        chk(switching, 1'b0, "sw");
        repeat (3000)
        begin
            @(posedge mclk);
            if (samp_valid === 1'b1)
                n++;
        end
        chk(16'(n), 16'h0000, "frames");
    endtask : t_off
    task conclude;
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    initial
    begin
        mismatches = 0;
        checked = 0;
        rst_n = 1'b0;
        {src_left, src_right} = {16'h1234, 16'h0234};
        {bclk_half, frame_sel, gain_sel, clip_level} = {4'h2, 2'h2, 2'h0, 14'h0000};
        {shutdown_req, sleep_req, rate_high, parallel_sel} = 4'h8;
        cyc(4);
        rst_n <= 1'b1;
        cyc(2);
        t_default;
        t_pins;
        t_sleep;
        t_rates;
        t_off;
        conclude;
    end
    initial
    begin
        cyc(90000);
        mismatches++;
        conclude;
    end
endmodule : test_amp_hardware_mode_config
